// file: afztl_top.sv
// Zone based arc fault trip logic with APB registers and interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "afztl_defines.svh"
module afztl_top
  import afztl_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int ZONES = 4,
  parameter int MAG_W = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CHANNELS-1:0] light_in,
  input wire logic [CHANNELS-1:0] pressure_in,
  input wire logic [2*CHANNELS-1:0] sensor_count_in,
  input wire logic [3:0] unit_count_in,
  input wire logic arc_binary_input_one,
  input wire logic sample_stb,
  input wire logic [3*MAG_W-1:0] phase_mag,
  input wire logic [MAG_W-1:0] residual_input_one,
  input wire logic [MAG_W-1:0] residual_input_two,
  input wire logic block_phase,
  input wire logic block_res,
  input wire logic [ZONES-1:0] block_zone,
  output logic [CHANNELS-1:0] light_detected,
  output logic arc_bi_status,
  output logic phase_start,
  output logic phase_blocked,
  output logic res_start,
  output logic res_blocked,
  output logic [ZONES-1:0] zone_trip,
  output logic [ZONES-1:0] zone_blocked,
  output logic [CHANNELS-1:0] sensor_fault,
  output logic unit_fault,
  output logic fast_output_one,
  output logic fast_output_two,
  output logic irq
);
  localparam int EV_W = 2 * ZONES + CHANNELS + 1;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] sens_cfg_r, sens_cfg_nxt;
  logic [31:0] zone_en_r, zone_en_nxt;
  logic [MAG_W-1:0] ph_limit_r, ph_limit_nxt;
  logic [MAG_W-1:0] res_limit_r, res_limit_nxt;
  logic [7:0] sample_req_r, sample_req_nxt;
  logic [EV_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [EV_W-1:0] irq_mask_r, irq_mask_nxt;
  logic [EV_W-1:0] ev_prev_r, ev_prev_nxt;
  logic [7:0] bi_cnt_r, bi_cnt_nxt;

  logic wr_en, rd_en;
  logic [EV_W-1:0] ev_now;
  logic [31:0] status_word;
  logic phase_over, res_over;
  afztl_res_sel_t res_sel;
  afztl_cur_if ph_if ();
  afztl_cur_if res_if ();

  // ****************************************************************
  // Current conditions
  // ****************************************************************
  always_comb begin
    phase_over = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (phase_mag[i*MAG_W +: MAG_W] > ph_limit_r) begin
        phase_over = 1'b1;
      end
    end
  end

  assign res_sel = afztl_res_sel_t'(ctrl_r[`AFZTL_CTRL_RESSEL_LSB +: 2]);

  always_comb begin
    case (res_sel)
      AFZTL_RES_ONE: res_over = residual_input_one > res_limit_r;
      AFZTL_RES_TWO: res_over = residual_input_two > res_limit_r;
      AFZTL_RES_NONE: res_over = 1'b0;
      default: res_over = 1'b0;
    endcase
  end

  assign ph_if.sample_stb = sample_stb;
  assign ph_if.over = phase_over;
  assign ph_if.req = sample_req_r;
  assign res_if.sample_stb = sample_stb;
  assign res_if.over = res_over;
  assign res_if.req = sample_req_r;

  afztl_cur_cond u_ph_cond (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .cif(ph_if.cond)
  );

  afztl_cur_cond u_res_cond (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .cif(res_if.cond)
  );

  assign phase_start = ph_if.active & ~block_phase;
  assign phase_blocked = ph_if.active & block_phase;
  assign res_start = res_if.active & ~block_res;
  assign res_blocked = res_if.active & block_res;

  // ****************************************************************
  // Sensor channels and binary input
  // ****************************************************************
  // Channels are evaluated every clock with no memory, so a fault or
  // light indication drops the cycle its cause goes away.
  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : g_chan
      assign light_detected[c] = light_in[c];
      assign sensor_fault[c] = sensor_count_in[2*c +: 2] !=
        sens_cfg_r[2*c +: 2];
    end
  endgenerate

  assign unit_fault = unit_count_in !=
    sens_cfg_r[`AFZTL_SENS_UNIT_LSB +: 4];

  // Test pulses from the external units are short; with the option on,
  // the line must stay energized past the pulse width to count. This
  // costs that much delay on a genuine arc input.
  always_comb begin
    bi_cnt_nxt = 8'h00;
    if (arc_binary_input_one && bi_cnt_r != 8'hFF) begin
      bi_cnt_nxt = bi_cnt_r + 8'h01;
    end else if (arc_binary_input_one) begin
      bi_cnt_nxt = bi_cnt_r;
    end
  end

  always_comb begin
    if (ctrl_r[`AFZTL_CTRL_SELFSUP_BIT]) begin
      arc_bi_status = arc_binary_input_one &&
        bi_cnt_r >= 8'(`AFZTL_TPULSE_CYC);
    end else begin
      arc_bi_status = arc_binary_input_one;
    end
  end

  // ****************************************************************
  // Zones
  // ****************************************************************
  genvar z;
  generate
    for (z = 0; z < ZONES; z++) begin : g_zone
      logic [7:0] zcfg;
      logic zlight;
      logic zcond;
      assign zcfg = zone_en_r[z*`AFZTL_ZONE_FIELD_W +: 8];
      assign zlight = |((light_in | pressure_in) &
        zcfg[CHANNELS-1:0]);
      assign zcond = zlight &
        (~zcfg[`AFZTL_ZONE_PH_BIT] | ph_if.active) &
        (~zcfg[`AFZTL_ZONE_RES_BIT] | res_if.active);
      assign zone_trip[z] = ctrl_r[`AFZTL_CTRL_ZONE_LSB + z] & zcond &
        ~block_zone[z];
      assign zone_blocked[z] = ctrl_r[`AFZTL_CTRL_ZONE_LSB + z] & zcond &
        block_zone[z];
    end
  endgenerate

  assign fast_output_one = |zone_trip;
  assign fast_output_two = phase_start | res_start;

  // ****************************************************************
  // APB slave and interrupt
  // ****************************************************************
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign ev_now = {unit_fault, sensor_fault, zone_blocked, zone_trip};
  assign irq = |(irq_stat_r & irq_mask_r);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ZONES-1:0] = zone_trip;
    status_word[8 +: ZONES] = zone_blocked;
    status_word[16 +: CHANNELS] = sensor_fault;
    status_word[20] = unit_fault;
    status_word[21] = phase_start;
    status_word[22] = phase_blocked;
    status_word[23] = res_start;
    status_word[24] = res_blocked;
    status_word[25] = arc_bi_status;
    status_word[26 +: CHANNELS] = light_detected;
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    sens_cfg_nxt = sens_cfg_r;
    zone_en_nxt = zone_en_r;
    ph_limit_nxt = ph_limit_r;
    res_limit_nxt = res_limit_r;
    sample_req_nxt = sample_req_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    ev_prev_nxt = ev_now;
    if (wr_en) begin
      case (paddr)
        `AFZTL_OFS_CTRL: ctrl_nxt = {25'h0000000, pwdata[6:0]};
        `AFZTL_OFS_SENS_CFG: sens_cfg_nxt = {20'h00000, pwdata[11:0]};
        `AFZTL_OFS_ZONE_EN: zone_en_nxt = pwdata & 32'h3F3F_3F3F;
        `AFZTL_OFS_PH_LIMIT: ph_limit_nxt = pwdata[MAG_W-1:0];
        `AFZTL_OFS_RES_LIMIT: res_limit_nxt = pwdata[MAG_W-1:0];
        `AFZTL_OFS_SAMPLE_REQ: sample_req_nxt = pwdata[7:0];
        `AFZTL_OFS_IRQ_MASK: irq_mask_nxt = pwdata[EV_W-1:0];
        default: ;
      endcase
    end
    if (rd_en && paddr == `AFZTL_OFS_IRQ_STAT) begin
      irq_stat_nxt = '0;
    end
    // A new event in the clearing cycle is kept.
    irq_stat_nxt = irq_stat_nxt | (ev_now & ~ev_prev_r);
  end

  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      `AFZTL_OFS_CTRL: prdata = ctrl_r;
      `AFZTL_OFS_SENS_CFG: prdata = sens_cfg_r;
      `AFZTL_OFS_ZONE_EN: prdata = zone_en_r;
      `AFZTL_OFS_PH_LIMIT: prdata[MAG_W-1:0] = ph_limit_r;
      `AFZTL_OFS_RES_LIMIT: prdata[MAG_W-1:0] = res_limit_r;
      `AFZTL_OFS_SAMPLE_REQ: prdata[7:0] = sample_req_r;
      `AFZTL_OFS_STATUS: prdata = status_word;
      `AFZTL_OFS_IRQ_STAT: prdata[EV_W-1:0] = irq_stat_r;
      `AFZTL_OFS_IRQ_MASK: prdata[EV_W-1:0] = irq_mask_r;
      default: pslverr = psel & penable;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_r <= `AFZTL_RST_CTRL;
      sens_cfg_r <= `AFZTL_RST_SENS_CFG;
      zone_en_r <= `AFZTL_RST_ZONE_EN;
      ph_limit_r <= `AFZTL_RST_LIMIT;
      res_limit_r <= `AFZTL_RST_LIMIT;
      sample_req_r <= `AFZTL_RST_SAMPLE_REQ;
      irq_mask_r <= `AFZTL_RST_IRQ_MASK;
      irq_stat_r <= '0;
      ev_prev_r <= '0;
      bi_cnt_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      sens_cfg_r <= sens_cfg_nxt;
      zone_en_r <= zone_en_nxt;
      ph_limit_r <= ph_limit_nxt;
      res_limit_r <= res_limit_nxt;
      sample_req_r <= sample_req_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_stat_r <= irq_stat_nxt;
      ev_prev_r <= ev_prev_nxt;
      bi_cnt_r <= bi_cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// file: afztl_defines.svh
// Offsets, field positions, reset values and timing counts of the arc trip block.
`ifndef AFZTL_DEFINES_SVH
`define AFZTL_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define AFZTL_OFS_CTRL 12'h000
`define AFZTL_OFS_SENS_CFG 12'h004
`define AFZTL_OFS_ZONE_EN 12'h008
`define AFZTL_OFS_PH_LIMIT 12'h00C
`define AFZTL_OFS_RES_LIMIT 12'h010
`define AFZTL_OFS_SAMPLE_REQ 12'h014
`define AFZTL_OFS_STATUS 12'h018
`define AFZTL_OFS_IRQ_STAT 12'h01C
`define AFZTL_OFS_IRQ_MASK 12'h020

// ****************************************************************
// Field positions
// ****************************************************************
`define AFZTL_CTRL_ZONE_LSB 0
`define AFZTL_CTRL_SELFSUP_BIT 4
`define AFZTL_CTRL_RESSEL_LSB 5
`define AFZTL_SENS_UNIT_LSB 8
`define AFZTL_ZONE_FIELD_W 8
`define AFZTL_ZONE_PH_BIT 4
`define AFZTL_ZONE_RES_BIT 5

// ****************************************************************
// Reset values
// ****************************************************************
`define AFZTL_RST_CTRL 32'h0000_0000
`define AFZTL_RST_SENS_CFG 32'h0000_0000
`define AFZTL_RST_ZONE_EN 32'h0000_0000
`define AFZTL_RST_LIMIT 16'h04B0
`define AFZTL_RST_SAMPLE_REQ 8'h02
`define AFZTL_RST_IRQ_MASK 13'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define AFZTL_CLK_NS 100
`define AFZTL_TPULSE_NS 1000
`define AFZTL_TPULSE_CYC (`AFZTL_TPULSE_NS / `AFZTL_CLK_NS)

`endif

// file: afztl_pkg.sv
// Types shared by the arc trip block.
`default_nettype none
package afztl_pkg;
  typedef enum logic [1:0] {
    AFZTL_RES_NONE = 2'b00,
    AFZTL_RES_ONE = 2'b01,
    AFZTL_RES_TWO = 2'b10
  } afztl_res_sel_t;

  typedef enum logic [1:0] {
    AFZTL_CC_IDLE = 2'b00,
    AFZTL_CC_COUNT = 2'b01,
    AFZTL_CC_ACTIVE = 2'b10
  } afztl_cc_state_t;
endpackage
`default_nettype wire

// file: afztl_cur_if.sv
// Link between the trip logic and one current condition counter.
`timescale 1ns/1ps
`default_nettype none
interface afztl_cur_if;
  logic sample_stb;
  logic over;
  logic [7:0] req;
  logic active;
  modport ctl (output sample_stb, output over, output req, input active);
  modport cond (input sample_stb, input over, input req, output active);
endinterface
`default_nettype wire

// file: afztl_cur_cond.sv
// Current condition: counts consecutive samples above the limit.
`timescale 1ns/1ps
`default_nettype none
module afztl_cur_cond
  import afztl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  afztl_cur_if.cond cif
);
  afztl_cc_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (cif.sample_stb) begin
      if (!cif.over) begin
        state_nxt = AFZTL_CC_IDLE;
        cnt_nxt = 8'h00;
      end else if (cnt_r + 8'h01 >= cif.req) begin
        state_nxt = AFZTL_CC_ACTIVE;
        cnt_nxt = cif.req;
      end else begin
        state_nxt = AFZTL_CC_COUNT;
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r <= AFZTL_CC_IDLE;
      cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_comb begin
    case (state_r)
      AFZTL_CC_ACTIVE: cif.active = 1'b1;
      AFZTL_CC_IDLE: cif.active = 1'b0;
      AFZTL_CC_COUNT: cif.active = 1'b0;
      default: cif.active = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: afztl_props.sv
// Concurrent checks on the ports of the arc trip block.
`timescale 1ns/1ps
`default_nettype none
module afztl_props #(
  parameter int CHANNELS = 4,
  parameter int ZONES = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [CHANNELS-1:0] light_in,
  input wire logic [CHANNELS-1:0] pressure_in,
  input wire logic arc_binary_input_one,
  input wire logic sample_stb,
  input wire logic block_phase,
  input wire logic block_res,
  input wire logic [ZONES-1:0] block_zone,
  input wire logic [CHANNELS-1:0] light_detected,
  input wire logic arc_bi_status,
  input wire logic phase_start,
  input wire logic phase_blocked,
  input wire logic res_start,
  input wire logic res_blocked,
  input wire logic [ZONES-1:0] zone_trip,
  input wire logic [ZONES-1:0] zone_blocked,
  input wire logic fast_output_one,
  input wire logic fast_output_two
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_light; light_detected == light_in; endproperty
  property p_fast; fast_output_one == (|zone_trip)
    && fast_output_two == (phase_start | res_start); endproperty
  property p_zblk; ((zone_trip & block_zone)
    | (zone_blocked & ~block_zone)) == '0; endproperty
  property p_zsrc; (zone_trip | zone_blocked) != '0
    |-> (light_in | pressure_in) != '0; endproperty
  property p_phblk; !(phase_start && block_phase)
    && !(phase_blocked && !block_phase); endproperty
  property p_rsblk; !(res_start && block_res)
    && !(res_blocked && !block_res); endproperty
  // The phase current condition may only start on a taken sample.
  property p_cnt; $rose(phase_start | phase_blocked)
    |-> $past(sample_stb); endproperty
  property p_arc; $rose(arc_bi_status) |-> arc_binary_input_one; endproperty
  a_light: assert property (p_light) else $error("light flag");
  a_fast: assert property (p_fast) else $error("fast output");
  a_zblk: assert property (p_zblk) else $error("zone block");
  a_zsrc: assert property (p_zsrc) else $error("zone no light");
  a_phblk: assert property (p_phblk) else $error("phase block");
  a_rsblk: assert property (p_rsblk) else $error("res block");
  a_cnt: assert property (p_cnt) else $error("start w/o sample");
  a_arc: assert property (p_arc) else $error("arc status");
  c_trip: cover property (zone_trip != '0);
  c_blk: cover property (zone_blocked != '0);
  c_ph: cover property ($rose(phase_start));
endmodule
`default_nettype wire

// file: afztl_arc_units.sv
// Behavioural model of the external arc sensors and arc units.
`timescale 1ns/1ps
`default_nettype none
module afztl_arc_units (
  input wire logic sys_clk,
  input wire logic pulse_en,
  input wire logic arc_cmd,
  input wire logic [3:0] light_cmd,
  input wire logic [3:0] press_cmd,
  input wire logic [7:0] cnt_cmd,
  input wire logic [3:0] unit_cmd,
  output logic [3:0] light_in,
  output logic [3:0] pressure_in,
  output logic [7:0] sensor_count_in,
  output logic [3:0] unit_count_in,
  output logic arc_binary_input_one
);
  logic [5:0] tick_r = 6'h00;
  initial {light_in, pressure_in, sensor_count_in, unit_count_in} = '0;
  initial arc_binary_input_one = 1'b0;
  // Pulses last three cycles, far shorter than a real arc indication.
  always @(posedge sys_clk) begin
    tick_r <= tick_r + 6'h01;
    light_in <= light_cmd;
    pressure_in <= press_cmd;
    sensor_count_in <= cnt_cmd;
    unit_count_in <= unit_cmd;
    arc_binary_input_one <= arc_cmd | (pulse_en && tick_r < 6'h03);
  end
endmodule
`default_nettype wire

// file: arc_fault_zone_trip_logic_tb.sv
// Self-checking bench for the arc trip block.
`timescale 1ns/1ps
`default_nettype none
`include "afztl_defines.svh"
module arc_fault_zone_trip_logic_tb;
  typedef struct packed {
    logic [3:0] ctl;
    logic [31:0] zen;
    logic [3:0] lt, pr, bz, trip, blk;
  } afztl_row_t;
  localparam afztl_row_t ROWS [6] = '{
    '{4'hF, 32'h08040201, 4'h5, 4'h0, 4'h0, 4'h5, 4'h0},
    '{4'hF, 32'h08040201, 4'h0, 4'hA, 4'h0, 4'hA, 4'h0},
    '{4'hF, 32'h08040201, 4'hF, 4'h0, 4'h3, 4'hC, 4'h3},
    '{4'h0, 32'h08040201, 4'hF, 4'h0, 4'h0, 4'h0, 4'h0},
    '{4'h8, 32'h0F000000, 4'h4, 4'h0, 4'h0, 4'h8, 4'h0},
    '{4'hF, 32'h08040211, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0}
  };
  localparam logic [43:0] REGS [6] = '{
    {`AFZTL_OFS_CTRL, 32'h0}, {`AFZTL_OFS_ZONE_EN, 32'h0},
    {`AFZTL_OFS_PH_LIMIT, 32'h04B0}, {`AFZTL_OFS_RES_LIMIT, 32'h04B0},
    {`AFZTL_OFS_SAMPLE_REQ, 32'h2}, {12'h100, 32'h0}
  };
  logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, sample_stb = 1'b0, block_phase = 1'b0;
  logic block_res = 1'b0, pulse_en = 1'b0, arc_cmd = 1'b0;
  logic [3:0] block_zone = 4'h0, light_cmd = 4'h0, press_cmd = 4'h0;
  logic [3:0] unit_cmd = 4'h0;
  logic [7:0] cnt_cmd = 8'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [47:0] phase_mag = 48'h0;
  logic [15:0] residual_input_one = 16'h0, residual_input_two = 16'h0;
  logic pready, pslverr, rd_err, arc_bi_status, phase_start, phase_blocked;
  logic res_start, res_blocked, unit_fault, fast_output_one, fast_output_two;
  logic irq, arc_binary_input_one;
  logic [3:0] light_in, pressure_in, unit_count_in, light_detected;
  logic [3:0] zone_trip, zone_blocked, sensor_fault;
  logic [7:0] sensor_count_in;
  int n_mismatch = 0, n_compared = 0, nl, ns;
  afztl_arc_units u_far (.sys_clk, .pulse_en, .arc_cmd, .light_cmd,
    .press_cmd, .cnt_cmd, .unit_cmd, .light_in, .pressure_in,
    .sensor_count_in, .unit_count_in, .arc_binary_input_one);
  afztl_top dut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .light_in, .pressure_in,
    .sensor_count_in, .unit_count_in, .arc_binary_input_one, .sample_stb,
    .phase_mag, .residual_input_one, .residual_input_two, .block_phase,
    .block_res, .block_zone, .light_detected, .arc_bi_status, .phase_start,
    .phase_blocked, .res_start, .res_blocked, .zone_trip, .zone_blocked,
    .sensor_fault, .unit_fault, .fast_output_one, .fast_output_two, .irq);
  always #50 sys_clk = ~sys_clk;
  task automatic end_of_test;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd_q = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic strobe(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      sample_stb <= 1'b1;
      @(posedge sys_clk);
      sample_stb <= 1'b0;
    end
    @(negedge sys_clk);
  endtask
  task automatic watch;
    nl = 0;
    ns = 0;
    repeat (130) begin
      @(negedge sys_clk);
      nl += int'(arc_binary_input_one);
      ns += int'(arc_bi_status);
    end
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (ROWS[i]) begin
      apb(1'b1, `AFZTL_OFS_CTRL, {28'h0, ROWS[i].ctl});
      apb(1'b1, `AFZTL_OFS_ZONE_EN, ROWS[i].zen);
      light_cmd <= ROWS[i].lt;
      press_cmd <= ROWS[i].pr;
      block_zone <= ROWS[i].bz;
      settle();
      chk(32'(zone_trip), 32'(ROWS[i].trip));
      chk(32'(zone_blocked), 32'(ROWS[i].blk));
      chk(32'(light_detected), 32'(ROWS[i].lt));
    end
    @(posedge sys_clk);
    {light_cmd, press_cmd, block_zone} <= 12'h000;
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (REGS[i]) begin
      apb(1'b0, REGS[i][43:32], 32'h0);
      chk(rd_q, REGS[i][31:0]);
      chk(32'(rd_err), 32'(REGS[i][43:32] == 12'h100));
    end
    cnt_cmd <= 8'h03;
    unit_cmd <= 4'h2;
    apb(1'b1, `AFZTL_OFS_SENS_CFG, 32'h0203);
    apb(1'b0, `AFZTL_OFS_IRQ_STAT, 32'h0);
    apb(1'b1, `AFZTL_OFS_IRQ_MASK, 32'h0100);
    apb(1'b0, `AFZTL_OFS_SENS_CFG, 32'h0);
    chk(rd_q, 32'h0000_0203);
    settle();
    chk(32'({unit_fault, sensor_fault, irq}), 32'h0);
    @(posedge sys_clk);
    cnt_cmd <= 8'h02;
    unit_cmd <= 4'h3;
    settle();
    chk(32'({unit_fault, sensor_fault}), 32'h11);
    settle();
    chk(32'(irq), 32'h1);
    apb(1'b0, `AFZTL_OFS_IRQ_STAT, 32'h0);
    chk(rd_q, 32'h1100);
    settle();
    chk(32'(irq), 32'h0);
    @(posedge sys_clk);
    phase_mag <= 48'h04B0_0000_0000;
    strobe(2);
    chk(32'(phase_start), 32'h0);
    @(posedge sys_clk);
    phase_mag <= 48'h04B1_0000_0000;
    strobe(1);
    chk(32'(phase_start), 32'h0);
    strobe(1);
    chk(32'({phase_start, phase_blocked, fast_output_two}), 32'h5);
    @(posedge sys_clk);
    block_phase <= 1'b1;
    @(negedge sys_clk);
    chk(32'({phase_start, phase_blocked}), 32'h1);
    apb(1'b1, `AFZTL_OFS_CTRL, 32'h1);
    apb(1'b1, `AFZTL_OFS_ZONE_EN, 32'h11);
    block_phase <= 1'b0;
    light_cmd <= 4'h1;
    settle();
    chk(32'({zone_trip, fast_output_one}), 32'h3);
    apb(1'b0, `AFZTL_OFS_STATUS, 32'h0);
    chk(rd_q, 32'h0431_0001);
    @(posedge sys_clk);
    phase_mag <= 48'h0;
    strobe(1);
    chk(32'({phase_start, zone_trip}), 32'h0);
    apb(1'b1, `AFZTL_OFS_CTRL, 32'h40);
    residual_input_one <= 16'hFFFF;
    strobe(2);
    chk(32'(res_start), 32'h0);
    @(posedge sys_clk);
    residual_input_two <= 16'hFFFF;
    strobe(2);
    chk(32'(res_start), 32'h1);
    @(posedge sys_clk);
    block_res <= 1'b1;
    @(negedge sys_clk);
    chk(32'({res_start, res_blocked}), 32'h1);
    apb(1'b1, `AFZTL_OFS_CTRL, 32'h20);
    block_res <= 1'b0;
    residual_input_one <= 16'h0000;
    strobe(1);
    chk(32'(res_start), 32'h0);
    @(posedge sys_clk);
    residual_input_one <= 16'hFFFF;
    strobe(2);
    chk(32'(res_start), 32'h1);
    apb(1'b1, `AFZTL_OFS_CTRL, 32'h10);
    pulse_en <= 1'b1;
    watch();
    chk(32'(nl > 0 && ns == 0), 32'h1);
    apb(1'b1, `AFZTL_OFS_CTRL, 32'h0);
    watch();
    chk(32'(ns > 0), 32'h1);
    apb(1'b1, `AFZTL_OFS_CTRL, 32'h10);
    pulse_en <= 1'b0;
    arc_cmd <= 1'b1;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(32'(arc_bi_status), 32'h0);
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(32'(arc_bi_status), 32'h1);
    end_of_test();
  end
endmodule
bind afztl_top afztl_props #(.CHANNELS(CHANNELS), .ZONES(ZONES)) u_props (
  .sys_clk, .resetn, .light_in, .pressure_in, .arc_binary_input_one,
  .sample_stb, .block_phase, .block_res, .block_zone, .light_detected,
  .arc_bi_status, .phase_start, .phase_blocked, .res_start, .res_blocked,
  .zone_trip, .zone_blocked, .fast_output_one, .fast_output_two);
`default_nettype wire
